// >>> vdc_consts.vh
// constants for the sync status and calibration register bank
// assumes a 200 MHz hclk and 32-bit AHB-Lite word addressing
`ifndef VDC_CONSTS_VH
`define VDC_CONSTS_VH

// register indices; byte address is four times the index
`define VDC_IDX_POL 6'h25
`define VDC_IDX_LPF_HI 6'h26
`define VDC_IDX_LPF_LO 6'h27
`define VDC_IDX_TEST1 6'h28
`define VDC_IDX_TEST2 6'h29
`define VDC_IDX_TEST3 6'h2A
`define VDC_IDX_TEST4 6'h2B
`define VDC_IDX_OFS_HOLD 6'h2C
`define VDC_IDX_TEST5 6'h2D
`define VDC_IDX_TEST6 6'h2E
`define VDC_IDX_SOG_FLT 6'h34
`define VDC_IDX_VCO_GEAR 6'h36
`define VDC_IDX_GAIN_MATCH 6'h3C

// field positions
`define VDC_POL_VS1_BIT 4
`define VDC_POL_COAST_BIT 3
`define VDC_POL_CLAMP_BIT 2
`define VDC_POL_EXTRA_BIT 1
`define VDC_OFS_HOLD_BIT 4
`define VDC_SOG_FLT_BIT 2
`define VDC_VCO_GEAR_BIT 0
`define VDC_GAIN_HOLD_BIT 3
`define VDC_GAIN_EN_MSB 2
`define VDC_GAIN_EN_ON 3'h6

// reset values
`define VDC_RST_TEST1 8'hBF
`define VDC_RST_TEST2 8'h00
`define VDC_RST_TEST5 8'hE8
`define VDC_RST_TEST6 8'hE0
`define VDC_RST_OFS_HOLD 8'h00
`define VDC_RST_GAIN_MATCH 8'h00
`define VDC_RST_RO 8'h00
`define VDC_RST_CAL 8'h80

// timing
`define VDC_CLK_NS 5
`define VDC_SOG_MIN_NS 250
`define VDC_SOG_MIN_CYC ((`VDC_SOG_MIN_NS + `VDC_CLK_NS - 1) / `VDC_CLK_NS)
`define VDC_UPDATE_HSYNCS 12'h040
`define VDC_LINES_MAX 12'hFFF
`define VDC_RUN_MAX 16'hFFFF

`endif

// >>> vdc_pol_det.v
// polarity detector for one asynchronous sync pin
// assumes a pulse is shorter than the gap between pulses
`timescale 1ns/10ps
`include "vdc_consts.vh"
module vdc_pol_det (
  // clock and reset
  input wire hclk,
  input wire hresetn,
  // pin and results
  input wire pin_in,
  output wire pin_sync,
  output reg polarity_q
);
  reg s1_q;
  reg s2_q;
  reg s3_q;
  reg [15:0] run_q;
  reg [15:0] hi_q;
  reg [15:0] lo_q;

  assign pin_sync = s2_q;

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
      run_q <= 16'h0000;
      hi_q <= 16'h0000;
      lo_q <= 16'h0000;
      polarity_q <= 1'b0;
    end else begin
      s1_q <= pin_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s3_q != s2_q) begin
        if (s3_q)
          hi_q <= run_q;
        else
          lo_q <= run_q;
        run_q <= 16'h0001;
      end else if (run_q != `VDC_RUN_MAX) begin
        run_q <= run_q + 16'h0001;
      end
      // short high phase means the pulse is active high
      polarity_q <= (hi_q != 16'h0000) && (lo_q != 16'h0000) && (hi_q < lo_q);
    end
  end
endmodule

// >>> vdc_sar_cal.v
// successive approximation calibration loop, then tracking
// assumes cmp_high is synchronous and means the value is too high
`timescale 1ns/10ps
`include "vdc_consts.vh"
module vdc_sar_cal (
  // clock and reset
  input wire hclk,
  input wire hresetn,
  // control
  input wire run,
  input wire tick,
  input wire cmp_high,
  // result
  output reg [7:0] value_q,
  output wire settled
);
  reg [7:0] mask_q;
  reg run_q;

  assign settled = (mask_q == 8'h00);

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      value_q <= `VDC_RST_CAL;
      mask_q <= 8'h80;
      run_q <= 1'b0;
    end else begin
      run_q <= run;
      if (run && !run_q) begin
        // fresh search: eight steps, inside the ten-update bound
        value_q <= `VDC_RST_CAL;
        mask_q <= 8'h80;
      end else if (run && tick) begin
        if (mask_q != 8'h00) begin
          value_q <= (cmp_high ? (value_q & ~mask_q) : value_q) | (mask_q >> 1);
          mask_q <= mask_q >> 1;
        end else if (cmp_high && value_q != 8'h00) begin
          value_q <= value_q - 8'h01;
        end else if (!cmp_high && value_q != 8'hFF) begin
          value_q <= value_q + 8'h01;
        end
      end
    end
  end
endmodule

// >>> vdc_sync_cal_regs.v
// sync status and calibration register bank, AHB-Lite slave
// assumes sync pins are asynchronous; comparators come from the analog front end
// Functional notes
// RULE1: status bit reports second vertical sync polarity, 1 positive, 0 negative.
// RULE2: status bit reports external coast input polarity, 1 positive.
// RULE3: status bit reports clamp signal polarity, 1 positive.
// RULE4: status bit reads 1 when extra pulses occur inside a horizontal line.
// RULE5: twelve-bit horizontal syncs per vertical sync, high byte then low nibble.
// RULE6: software writes 0xBF to the first test register.
// RULE7: software writes zero to second test register and offset-hold spare bits.
// RULE8: software writes 0xE8 and 0xE0 to fifth and sixth test registers.
// RULE9: third and fourth test registers are read-only.
// RULE10: offset hold bit 1 updates offset continuously, 0 freezes it.
// RULE11: one-time offset: enable, set hold, wait, clear hold.
// RULE12: offset and gain loops settle within ten update intervals.
// RULE13: software should prefer continuous updates, else redo after power-up or mode change.
// RULE14: green sync filter rejects pulses narrower than 250 ns when enabled.
// RULE15: gear bit 1 selects the low oscillator range.
// RULE16: software keeps gain register upper four bits zero.
// RULE17: gain hold 1 updates gains continuously, 0 freezes; resets to 0.
// RULE18: one-time gain: enable, set hold, wait, clear hold.
// RULE19: gain field 000 disables gain matching, 110 enables it.
// RULE20: software writes only 000 or 110 to the gain enable field.
// RULE21: writes to polarity and sync count registers are ignored.
//
// Register access over AHB-Lite was chosen for this implementation.
`timescale 1ns/10ps
`include "vdc_consts.vh"
module vdc_sync_cal_regs (
  // clock and reset
  input wire hclk,
  input wire hresetn,
  // ahb-lite slave
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output wire hreadyout,
  output wire hresp,
  output reg [31:0] hrdata,
  // sync pins
  input wire active_hsync,
  input wire active_vsync,
  input wire second_vertical_sync_input,
  input wire coast_in,
  input wire clamp_in,
  input wire sync_on_green,
  // calibration comparators and enables
  input wire auto_offset_en,
  input wire offset_cmp_high,
  input wire gain_cmp_high,
  // outputs to the analog side
  output reg sync_on_green_filtered,
  output wire green_sync_pulse_filter_on,
  output wire oscillator_low_range,
  output wire [7:0] offset_value,
  output wire [7:0] gain_value,
  output wire offset_settled,
  output wire gain_settled
);
  // register state
  reg [7:0] test1_q;
  reg [7:0] test2_q;
  reg [7:0] test5_q;
  reg [7:0] test6_q;
  reg [7:0] ofs_hold_q;
  reg sog_flt_q;
  reg vco_gear_q;
  reg [7:0] gain_match_q;
  // bus data phase
  reg wr_pend_q;
  reg [5:0] wr_idx_q;
  // synchronisers for non-polarity inputs
  reg [2:0] cmp_s1_q;
  reg [2:0] cmp_s2_q;
  // sync edge tracking
  reg hs_prev_q;
  reg vs_prev_q;
  // line and frame counting
  reg [11:0] line_acc_q;
  reg [11:0] line_cnt_q;
  reg [15:0] period_run_q;
  reg [15:0] period_q;
  reg extra_acc_q;
  reg extra_q;
  // update tick
  reg [11:0] upd_cnt_q;
  // green sync filter
  reg [7:0] sog_run_q;
  reg sog_prev_q;

  wire hs_sync;
  wire vs_sync;
  wire vs1_sync;
  wire coast_sync;
  wire clamp_sync;
  wire hs_pol;
  wire vs_pol;
  wire vs1_pol;
  wire coast_pol;
  wire clamp_pol;
  wire hs_act;
  wire vs_act;
  wire hs_lead;
  wire vs_lead;
  wire short_line;
  wire upd_tick;
  wire ofs_run;
  wire gain_run;
  wire sog_sync;
  wire bus_req;
  wire [5:0] req_idx;
  wire addr_ok;
  wire [7:0] status_byte;

  // polarity detectors also supply the synchronised pin level
  vdc_pol_det u_pol_hs (
    .hclk(hclk),
    .hresetn(hresetn),
    .pin_in(active_hsync),
    .pin_sync(hs_sync),
    .polarity_q(hs_pol)
  );

  vdc_pol_det u_pol_vs (
    .hclk(hclk),
    .hresetn(hresetn),
    .pin_in(active_vsync),
    .pin_sync(vs_sync),
    .polarity_q(vs_pol)
  );

  vdc_pol_det u_pol_vs1 (
    .hclk(hclk),
    .hresetn(hresetn),
    .pin_in(second_vertical_sync_input),
    .pin_sync(vs1_sync),
    .polarity_q(vs1_pol)
  );

  vdc_pol_det u_pol_coast (
    .hclk(hclk),
    .hresetn(hresetn),
    .pin_in(coast_in),
    .pin_sync(coast_sync),
    .polarity_q(coast_pol)
  );

  vdc_pol_det u_pol_clamp (
    .hclk(hclk),
    .hresetn(hresetn),
    .pin_in(clamp_in),
    .pin_sync(clamp_sync),
    .polarity_q(clamp_pol)
  );

  // status byte: unused bit positions read zero
  assign status_byte = {3'b000,
                        vs1_pol,   // [RULE1]
                        coast_pol, // [RULE2]
                        clamp_pol, // [RULE3]
                        extra_q,   // [RULE4]
                        1'b0};

  // normalise syncs to active high before edge detection
  assign hs_act = hs_pol ? hs_sync : ~hs_sync;
  assign vs_act = vs_pol ? vs_sync : ~vs_sync;
  assign hs_lead = hs_act & ~hs_prev_q;
  assign vs_lead = vs_act & ~vs_prev_q;
  // a leading edge before half a line is an extra pulse
  assign short_line = (period_q != 16'h0000) && (period_run_q < {1'b0, period_q[15:1]});

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hs_prev_q <= 1'b1; // act level reads high while polarity is unknown: no false lead
      vs_prev_q <= 1'b1;
      line_acc_q <= 12'h000;
      line_cnt_q <= 12'h000;
      period_run_q <= 16'h0000;
      period_q <= 16'h0000;
      extra_acc_q <= 1'b0;
      extra_q <= 1'b0;
    end else begin
      hs_prev_q <= hs_act;
      vs_prev_q <= vs_act;
      if (period_run_q != `VDC_RUN_MAX)
        period_run_q <= period_run_q + 16'h0001;
      if (hs_lead && !short_line) begin
        period_q <= period_run_q;
        period_run_q <= 16'h0000;
      end
      if (vs_lead) begin
        // frame ends: publish counts, restart accumulation
        line_cnt_q <= line_acc_q; // [RULE5]
        line_acc_q <= {11'h000, hs_lead && !short_line};
        extra_q <= extra_acc_q | (hs_lead & short_line); // [RULE4]
        extra_acc_q <= 1'b0;
      end else begin
        if (hs_lead && !short_line && line_acc_q != `VDC_LINES_MAX)
          line_acc_q <= line_acc_q + 12'h001; // [RULE5]
        if (hs_lead && short_line)
          extra_acc_q <= 1'b1; // [RULE4]
      end
    end
  end

  // calibration update interval counted in lines
  assign upd_tick = hs_lead && !short_line && (upd_cnt_q == `VDC_UPDATE_HSYNCS - 12'h001);

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      upd_cnt_q <= 12'h000;
    end else if (hs_lead && !short_line) begin
      if (upd_cnt_q == `VDC_UPDATE_HSYNCS - 12'h001)
        upd_cnt_q <= 12'h000;
      else
        upd_cnt_q <= upd_cnt_q + 12'h001;
    end
  end

  // comparator inputs cross from the analog side
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cmp_s1_q <= 3'b000;
      cmp_s2_q <= 3'b000;
    end else begin
      cmp_s1_q <= {sync_on_green, gain_cmp_high, offset_cmp_high};
      cmp_s2_q <= cmp_s1_q;
    end
  end

  assign sog_sync = cmp_s2_q[2];
  assign ofs_run = auto_offset_en & ofs_hold_q[`VDC_OFS_HOLD_BIT]; // [RULE10]
  // reserved enable codes leave gain matching off
  assign gain_run = (gain_match_q[`VDC_GAIN_EN_MSB:0] == `VDC_GAIN_EN_ON) // [RULE19]
                    & gain_match_q[`VDC_GAIN_HOLD_BIT]; // [RULE17]

  // both loops finish the search in eight updates [RULE12]
  vdc_sar_cal u_cal_ofs (
    .hclk(hclk),
    .hresetn(hresetn),
    .run(ofs_run),
    .tick(upd_tick),
    .cmp_high(cmp_s2_q[0]),
    .value_q(offset_value),
    .settled(offset_settled)
  );

  vdc_sar_cal u_cal_gain (
    .hclk(hclk),
    .hresetn(hresetn),
    .run(gain_run),
    .tick(upd_tick),
    .cmp_high(cmp_s2_q[1]),
    .value_q(gain_value),
    .settled(gain_settled)
  );

  // green sync filter: a level must hold for the minimum width to pass
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sog_run_q <= 8'h00;
      sog_prev_q <= 1'b0;
      sync_on_green_filtered <= 1'b0;
    end else begin
      sog_prev_q <= sog_sync;
      if (sog_sync != sog_prev_q)
        sog_run_q <= 8'h01;
      else if (sog_run_q != 8'hFF)
        sog_run_q <= sog_run_q + 8'h01;
      if (!sog_flt_q)
        sync_on_green_filtered <= sog_sync; // [RULE14]
      else if (sog_sync == sog_prev_q && {24'h000000, sog_run_q} >= (`VDC_SOG_MIN_CYC - 1))
        sync_on_green_filtered <= sog_sync; // [RULE14]
    end
  end

  assign green_sync_pulse_filter_on = sog_flt_q;
  assign oscillator_low_range = vco_gear_q; // [RULE15]

  // ahb-lite: zero wait states, always OKAY
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign bus_req = hsel & hready & htrans[1];
  assign req_idx = haddr[7:2];
  assign addr_ok = (haddr[31:8] == 24'h000000) & (haddr[1:0] == 2'b00);

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      wr_idx_q <= 6'h00;
      hrdata <= 32'h00000000;
    end else begin
      wr_pend_q <= bus_req & hwrite & addr_ok;
      wr_idx_q <= req_idx;
      if (bus_req && !hwrite) begin
        hrdata <= 32'h00000000;
        if (addr_ok) begin
          case (req_idx)
            `VDC_IDX_POL: hrdata[7:0] <= status_byte;
            `VDC_IDX_LPF_HI: hrdata[7:0] <= line_cnt_q[11:4]; // [RULE5]
            `VDC_IDX_LPF_LO: hrdata[7:0] <= {line_cnt_q[3:0], 4'h0}; // [RULE5]
            `VDC_IDX_TEST1: hrdata[7:0] <= test1_q;
            `VDC_IDX_TEST2: hrdata[7:0] <= test2_q;
            `VDC_IDX_TEST3: hrdata[7:0] <= `VDC_RST_RO; // [RULE9]
            `VDC_IDX_TEST4: hrdata[7:0] <= `VDC_RST_RO; // [RULE9]
            `VDC_IDX_OFS_HOLD: hrdata[7:0] <= ofs_hold_q;
            `VDC_IDX_TEST5: hrdata[7:0] <= test5_q;
            `VDC_IDX_TEST6: hrdata[7:0] <= test6_q;
            `VDC_IDX_SOG_FLT: hrdata[`VDC_SOG_FLT_BIT] <= sog_flt_q;
            `VDC_IDX_VCO_GEAR: hrdata[`VDC_VCO_GEAR_BIT] <= vco_gear_q;
            `VDC_IDX_GAIN_MATCH: hrdata[7:0] <= gain_match_q;
            default: hrdata <= 32'h00000000;
          endcase
        end
      end
    end
  end

  // write data arrives in the data phase; read-only indices fall through
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      test1_q <= `VDC_RST_TEST1;
      test2_q <= `VDC_RST_TEST2;
      test5_q <= `VDC_RST_TEST5;
      test6_q <= `VDC_RST_TEST6;
      ofs_hold_q <= `VDC_RST_OFS_HOLD;
      sog_flt_q <= 1'b0;
      vco_gear_q <= 1'b0;
      gain_match_q <= `VDC_RST_GAIN_MATCH; // [RULE17]
    end else if (wr_pend_q) begin
      case (wr_idx_q)
        `VDC_IDX_TEST1: test1_q <= hwdata[7:0];
        `VDC_IDX_TEST2: test2_q <= hwdata[7:0];
        `VDC_IDX_OFS_HOLD: ofs_hold_q <= hwdata[7:0]; // [RULE10]
        `VDC_IDX_TEST5: test5_q <= hwdata[7:0];
        `VDC_IDX_TEST6: test6_q <= hwdata[7:0];
        `VDC_IDX_SOG_FLT: sog_flt_q <= hwdata[`VDC_SOG_FLT_BIT]; // [RULE14]
        `VDC_IDX_VCO_GEAR: vco_gear_q <= hwdata[`VDC_VCO_GEAR_BIT]; // [RULE15]
        `VDC_IDX_GAIN_MATCH: gain_match_q <= hwdata[7:0]; // [RULE19]
        default: test1_q <= test1_q; // [RULE21] [RULE9]
      endcase
    end
  end
endmodule

// >>> vdc_sync_cal_regs_monitor.sv
// concurrent checks for the sync status and calibration register bank
// bound to the bank top; sees only its ports and shadows two control registers
`timescale 1ns/10ps
`include "vdc_consts.vh"
module vdc_sync_cal_regs_monitor (
  // clock and reset
  input wire hclk,
  input wire hresetn,
  // bus
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [31:0] hwdata,
  input wire hready,
  // pins and results
  input wire active_hsync,
  input wire auto_offset_en,
  input wire sync_on_green,
  input wire sync_on_green_filtered,
  input wire green_sync_pulse_filter_on,
  input wire oscillator_low_range,
  input wire [7:0] offset_value,
  input wire [7:0] gain_value,
  input wire offset_settled,
  input wire gain_settled
);
  reg wr_q, hs_q, sog_q;
  reg [5:0] idx_q;
  reg [7:0] ofs_q, gm_q, srun_q;
  reg [1:0] oidle_q, gidle_q;
  reg [3:0] fon_q, foff_q;
  reg [9:0] ohs_q, ghs_q;
  wire orun = auto_offset_en && ofs_q[`VDC_OFS_HOLD_BIT];
  wire grun = gm_q[`VDC_GAIN_HOLD_BIT] && gm_q[2:0] == `VDC_GAIN_EN_ON;
  wire hs_edge = active_hsync && !hs_q;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      {wr_q, hs_q, sog_q, idx_q, ofs_q, gm_q, srun_q} <= 33'h0;
      {oidle_q, gidle_q, fon_q, foff_q, ohs_q, ghs_q} <= 32'h0;
    end else begin
      // only word aligned addresses inside the bank reach a register
      wr_q <= hsel && hready && htrans[1] && hwrite && haddr[31:8] == 24'h0 && haddr[1:0] == 2'h0;
      idx_q <= haddr[7:2];
      hs_q <= active_hsync;
      sog_q <= sync_on_green;
      if (wr_q && idx_q == `VDC_IDX_OFS_HOLD) ofs_q <= hwdata[7:0];
      if (wr_q && idx_q == `VDC_IDX_GAIN_MATCH) gm_q <= hwdata[7:0];
      srun_q <= (sync_on_green != sog_q) ? 8'h00 : srun_q + {7'h0, srun_q != 8'hFF};
      oidle_q <= orun ? 2'h0 : oidle_q + {1'b0, oidle_q != 2'h3};
      gidle_q <= grun ? 2'h0 : gidle_q + {1'b0, gidle_q != 2'h3};
      fon_q <= green_sync_pulse_filter_on ? fon_q + {3'h0, fon_q != 4'hF} : 4'h0;
      foff_q <= green_sync_pulse_filter_on ? 4'h0 : foff_q + {3'h0, foff_q != 4'hF};
      // counts hsync edges since the loop was let run; extra pulses are kept off the pins meanwhile
      ohs_q <= orun ? ohs_q + {9'h0, hs_edge && ohs_q != 10'h3FF} : 10'h0;
      ghs_q <= grun ? ghs_q + {9'h0, hs_edge && ghs_q != 10'h3FF} : 10'h0;
    end
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  a_gear_follows_write: assert property (
    wr_q && idx_q == `VDC_IDX_VCO_GEAR |=> oscillator_low_range == $past(hwdata[0]))
    else $error("gear output differs from written bit");
  a_filter_bit_write: assert property (
    wr_q && idx_q == `VDC_IDX_SOG_FLT |=> green_sync_pulse_filter_on == $past(hwdata[2]))
    else $error("filter enable output differs from written bit");
  a_offset_frozen: assert property (oidle_q == 2'h3 && !orun |=> $stable(offset_value))
    else $error("offset moved while hold bit clear");
  a_gain_frozen: assert property (gidle_q == 2'h3 && !grun |=> $stable(gain_value))
    else $error("gain moved while matching stopped");
  a_short_pulse_blocked: assert property (
    fon_q == 4'hF && $changed(sync_on_green_filtered) |-> srun_q >= 8'd45)
    else $error("filtered green sync followed a short pulse");
  a_bypass_follows: assert property (
    foff_q == 4'hF && $rose(sync_on_green) |-> ##[1:6] sync_on_green_filtered)
    else $error("bypassed green sync did not follow");
  a_offset_settle_bound: assert property (ohs_q == 10'd660 |-> offset_settled)
    else $error("offset not settled within ten updates");
  a_gain_settle_bound: assert property (ghs_q == 10'd660 |-> gain_settled)
    else $error("gain not settled within ten updates");
  c_gain_settled: cover property ($rose(gain_settled));
  c_filter_passes: cover property (fon_q == 4'hF && $rose(sync_on_green_filtered));
  c_gear_write: cover property (wr_q && idx_q == `VDC_IDX_VCO_GEAR);
endmodule

bind vdc_sync_cal_regs vdc_sync_cal_regs_monitor u_mon (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
  .hwdata, .hready, .active_hsync, .auto_offset_en, .sync_on_green, .sync_on_green_filtered,
  .green_sync_pulse_filter_on, .oscillator_low_range, .offset_value, .gain_value, .offset_settled, .gain_settled);

// >>> vdc_sync_cal_regs_test.sv
// self-checking bench for the sync status and calibration register bank
// drives bus, sync pins and comparators itself; a byte model holds expected registers
`timescale 1ns/10ps
`include "vdc_consts.vh"
module vdc_sync_cal_regs_test;
  reg hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  reg [31:0] haddr = 32'h0, hwdata = 32'h0;
  reg [1:0] htrans = 2'h0;
  reg [2:0] hsize = 3'h2;
  reg active_hsync = 1'b0, active_vsync = 1'b0, second_vertical_sync_input = 1'b0, coast_in = 1'b0;
  reg clamp_in = 1'b0, sync_on_green = 1'b0, auto_offset_en = 1'b0, offset_cmp_high = 1'b0, gain_cmp_high = 1'b0;
  wire hreadyout, hresp, sync_on_green_filtered, green_sync_pulse_filter_on, oscillator_low_range;
  wire offset_settled, gain_settled;
  wire [31:0] hrdata;
  wire [7:0] offset_value, gain_value;
  reg gen_on = 1'b0, xtra = 1'b0;
  reg [2:0] pol = 3'h0;
  int lpf = 20, cyc = 0, line = 0, cycles = 0, fail_count = 0, tests_run = 0;
  logic [7:0] mdl [0:63];
  logic [5:0] regs [0:14] = '{`VDC_IDX_POL, `VDC_IDX_LPF_HI, `VDC_IDX_LPF_LO, `VDC_IDX_TEST1, `VDC_IDX_TEST2,
    `VDC_IDX_TEST3, `VDC_IDX_TEST4, `VDC_IDX_OFS_HOLD, `VDC_IDX_TEST5, `VDC_IDX_TEST6, `VDC_IDX_SOG_FLT,
    `VDC_IDX_VCO_GEAR, `VDC_IDX_GAIN_MATCH, 6'h30, 6'h00};

  vdc_sync_cal_regs dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout),
    .hreadyout, .hresp, .hrdata, .active_hsync, .active_vsync, .second_vertical_sync_input, .coast_in, .clamp_in,
    .sync_on_green, .auto_offset_en, .offset_cmp_high, .gain_cmp_high, .sync_on_green_filtered,
    .green_sync_pulse_filter_on, .oscillator_low_range, .offset_value, .gain_value, .offset_settled, .gain_settled);

  always #2.5 hclk = ~hclk;

  // lines of 20 cycles; hsync and the measured pins are active for 4 of them
  always @(posedge hclk) begin
    offset_cmp_high <= $urandom_range(1);
    gain_cmp_high <= $urandom_range(1);
    cyc <= (!gen_on || cyc == 19) ? 0 : cyc + 1;
    if (!gen_on) line <= 0;
    else if (cyc == 19) line <= (line >= lpf - 1) ? 0 : line + 1;
    active_hsync <= gen_on && (cyc < 4 || (xtra && line == 5 && (cyc == 6 || cyc == 7)));
    active_vsync <= gen_on && ((line == 0 && cyc >= 10) || (line == 1 && cyc < 10));
    second_vertical_sync_input <= (cyc < 4) ~^ pol[2];
    coast_in <= (cyc < 4) ~^ pol[1];
    clamp_in <= (cyc < 4) ~^ pol[0];
  end

  always @(posedge hclk) begin
    cycles <= cycles + 1;
    if (cycles == 80000) begin
      fail_count++;
      conclude;
    end
  end

  task automatic conclude;
    if (fail_count == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic xfer(input logic w, input logic [5:0] idx, input logic [7:0] wd, output logic [31:0] rd);
    hsel <= 1'b1;
    haddr <= {24'h0, idx, 2'b00};
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= {24'h0, wd};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  function automatic logic [7:0] wmask(input logic [5:0] idx);
    case (idx)
      `VDC_IDX_TEST1, `VDC_IDX_TEST2, `VDC_IDX_OFS_HOLD, `VDC_IDX_TEST5, `VDC_IDX_TEST6: return 8'hFF;
      `VDC_IDX_GAIN_MATCH: return 8'hFF;
      `VDC_IDX_SOG_FLT: return 8'h04;
      `VDC_IDX_VCO_GEAR: return 8'h01;
      default: return 8'h00;
    endcase
  endfunction

  task automatic wr(input logic [5:0] idx, input logic [7:0] d);
    logic [31:0] rd;
    xfer(1'b1, idx, d, rd);
    check("write response", hresp, 1'b0);
    mdl[idx] = (mdl[idx] & ~wmask(idx)) | (d & wmask(idx));
  endtask

  task automatic rd_chk(input logic [5:0] idx);
    logic [31:0] rd;
    xfer(1'b0, idx, 8'h00, rd);
    check($sformatf("register %h", idx), rd, {24'h0, mdl[idx]});
  endtask

  task automatic watch(input int n, output logic seen);
    seen = 1'b0;
    repeat (n) begin
      @(posedge hclk);
      seen = seen | sync_on_green_filtered;
    end
  endtask

  initial begin
    logic [31:0] rd;
    logic [7:0] hold_o, hold_g;
    logic seen;
    int k, r;
    r = $urandom(32'h82f6f8e5);
    for (k = 0; k < 64; k++) mdl[k] = 8'h00;
    mdl[`VDC_IDX_TEST1] = `VDC_RST_TEST1;
    mdl[`VDC_IDX_TEST5] = `VDC_RST_TEST5;
    mdl[`VDC_IDX_TEST6] = `VDC_RST_TEST6;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    foreach (regs[i]) rd_chk(regs[i]);
    // random data everywhere, read-only and unmapped places included
    foreach (regs[i]) wr(regs[i], $urandom_range(255));
    foreach (regs[i]) rd_chk(regs[i]);
    for (k = 0; k < 2; k++) begin
      wr(`VDC_IDX_VCO_GEAR, k[7:0]);
      @(posedge hclk);
      check("gear output", oscillator_low_range, k[0]);
      wr(`VDC_IDX_SOG_FLT, {5'h0, k[0], 2'h0});
      @(posedge hclk);
      check("filter output", green_sync_pulse_filter_on, k[0]);
    end
    wr(`VDC_IDX_TEST1, 8'hBF);
    wr(`VDC_IDX_TEST2, 8'h00);
    wr(`VDC_IDX_OFS_HOLD, 8'h00);
    wr(`VDC_IDX_TEST5, 8'hE8);
    wr(`VDC_IDX_TEST6, 8'hE0);
    wr(`VDC_IDX_GAIN_MATCH, 8'h00);
    foreach (regs[i]) rd_chk(regs[i]);
    for (k = 0; k < 2; k++) begin
      gen_on <= 1'b0;
      r = $urandom_range(7);
      @(posedge hclk);
      pol <= (k != 0) ? ~pol : r[2:0];
      xtra <= (k == 0);
      lpf <= $urandom_range(47, 16);
      gen_on <= 1'b1;
      repeat (2880) @(posedge hclk);
      xfer(1'b0, `VDC_IDX_POL, 8'h00, rd);
      check("polarity and extra pulses", rd[4:1], {pol, xtra});
      xfer(1'b0, `VDC_IDX_LPF_HI, 8'h00, rd);
      check("line count high", rd[7:0], lpf[11:4]);
      xfer(1'b0, `VDC_IDX_LPF_LO, 8'h00, rd);
      check("line count low", rd[7:4], lpf[3:0]);
    end
    // one-time calibration: let both loops run, then freeze them
    auto_offset_en <= 1'b1;
    wr(`VDC_IDX_OFS_HOLD, 8'h10);
    wr(`VDC_IDX_GAIN_MATCH, 8'h0E);
    repeat (14000) @(posedge hclk);
    check("offset settled", offset_settled, 1'b1);
    check("gain settled", gain_settled, 1'b1);
    wr(`VDC_IDX_OFS_HOLD, 8'h00);
    wr(`VDC_IDX_GAIN_MATCH, 8'h06);
    repeat (2) @(posedge hclk);
    hold_o = offset_value;
    hold_g = gain_value;
    repeat (4000) @(posedge hclk);
    check("offset held", offset_value, hold_o);
    check("gain held", gain_value, hold_g);
    for (k = 0; k < 8; k++) begin
      wr(`VDC_IDX_GAIN_MATCH, 8'h08 | k[7:0]);
      repeat (2) @(posedge hclk);
      hold_g = gain_value;
      repeat (2600) @(posedge hclk);
      if (k != 6) check("gain with matching off", gain_value, hold_g);
    end
    wr(`VDC_IDX_SOG_FLT, 8'h04);
    sync_on_green <= 1'b1;
    repeat (30) @(posedge hclk);
    sync_on_green <= 1'b0;
    watch(70, seen);
    check("short green pulse", seen, 1'b0);
    sync_on_green <= 1'b1;
    repeat (70) @(posedge hclk);
    check("long green pulse", sync_on_green_filtered, 1'b1);
    sync_on_green <= 1'b0;
    repeat (70) @(posedge hclk);
    wr(`VDC_IDX_SOG_FLT, 8'h00);
    repeat (20) @(posedge hclk);
    sync_on_green <= 1'b1;
    repeat (4) @(posedge hclk);
    sync_on_green <= 1'b0;
    watch(8, seen);
    check("bypassed green pulse", seen, 1'b1);
    conclude;
  end
endmodule
